//--- design/acs_params.svh
/*
 * Constants of the conversion sequencer: register offsets, field
 * positions, reset values and half-cycle timing counts.
 * Assumes inclusion by bare name from the design files.
 */
// What this block does
// [R01] Prescaler counts while converter enabled, held in reset while disabled.
// [R02] Software start begins conversion at next rising converter clock edge.
// [R03] Normal conversion lasts 13 converter clock cycles.
// [R04] First conversion after enabling lasts 25 converter clock cycles.
// [R05] Sample-and-hold at 1.5 cycles normally, 13.5 cycles on first.
// [R06] Completion stores result, sets done flag, clears start if single.
// [R07] Trigger resets prescaler; sample-and-hold two cycles after trigger edge.
// [R08] Trigger synchronisation adds three CPU clock cycles of latency.
// [R09] Differential auto-triggered conversions, non-free-running, take 25 cycles.
// [R10] Free running restarts at completion, start bit stays high.
// [R11] Differential conversions align to the half-rate converter clock.
// [R12] User differential start takes 13 cycles when half-rate low, else 14.
// [R13] Free-running differential restarts after the first take 14 cycles.
// [R14] Software toggles enable between auto-triggered differential conversions.
// [R15] Selection passes a holding register, locked during a conversion.
// [R16] Selection turns transparent again in the conversion's last cycle.
// [R17] Software waits one converter cycle after start before reselecting.
// [R18] Software changes selection only in the three safe windows.
// [R19] Software waits 125 us after a new differential channel.
// [R20] Free-running next conversion keeps old channel after a change.
// [R21] Software discards first result after changing reference.
// [R22] Software keeps converter clock within 50 to 200 kHz.
// [R23] Low byte read blocks result updates until high byte read.
// [R24] Trigger positive edge starts; edges during conversion are ignored.
// [R25] Software clears the trigger flag before the next trigger.
// [R26] Divisor-select field sets prescaler division of the CPU clock.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACS_OFF_CTRL   3'h0
`define ACS_OFF_SEL    3'h1
`define ACS_OFF_TRIG   3'h2
`define ACS_OFF_RES_LO 3'h3
`define ACS_OFF_RES_HI 3'h4

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ACS_B_EN    7
`define ACS_B_START 6
`define ACS_B_AUTO  5
`define ACS_B_DONE  4
`define ACS_B_DIFF  4
`define ACS_SEL_RST 7'h00
`define ACS_DIV_RST 3'h0
`define ACS_SRC_RST 3'h0

// ----------------------------------------------------------------
// Timing in half converter clock cycles from the start
// ----------------------------------------------------------------
`define ACS_HC_W       6
`define ACS_SH_NORM    6'h03
`define ACS_DONE_NORM  6'h1A
`define ACS_SH_FIRST   6'h1B
`define ACS_DONE_FIRST 6'h32
`define ACS_SH_AUTO    6'h04
`define ACS_DONE_AUTO  6'h1B
`define ACS_SH_DLONG   6'h05
`define ACS_DONE_DLONG 6'h1C
`define ACS_SYNC_LAT   3

`endif

//--- design/acs_pkg.sv
/*
 * Types of the conversion sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acs_pkg;
	typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_t;
	typedef enum logic [1:0] {
		ACS_K_NORMAL,
		ACS_K_FIRST,
		ACS_K_AUTO,
		ACS_K_DLONG
	} acs_kind_t;
endpackage

//--- design/acs_seq_if.sv
/*
 * Carrier between the sequencer core, its prescaler and its trigger
 * synchroniser. Assumes all three run on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface acs_seq_if;
	logic       enable;
	logic       presc_clr;
	logic [2:0] divisor;
	logic       tick_rise;
	logic       tick_fall;
	logic       conv_clk;
	logic [2:0] trig_src;
	logic       trig_edge;

	modport presc (input enable, presc_clr, divisor,
	               output tick_rise, tick_fall, conv_clk);
	modport trig  (input enable, trig_src, output trig_edge);
	modport core  (output enable, presc_clr, divisor, trig_src,
	               input tick_rise, tick_fall, conv_clk, trig_edge);
endinterface
`default_nettype wire

//--- design/acs_prescaler.sv
/*
 * Converter clock prescaler: divides the CPU clock by 2 to 256.
 * Assumes the core drives enable and clear on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_prescaler #(
	parameter int CNT_W = 8
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	acs_seq_if.presc  sif
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W:0]   div_full;
	logic [CNT_W-1:0] limit;
	logic [CNT_W-1:0] half;
	logic             run;

	// ----------------------------------------------------------------
	// Division ratio
	// ----------------------------------------------------------------
	assign div_full = (CNT_W+1)'(2) << sif.divisor;            // R26
	assign limit    = CNT_W'(div_full - (CNT_W+1)'(1));
	assign half     = limit >> 1;
	assign run      = sif.enable && !sif.presc_clr;             // R01

	assign cnt_d = !run ? '0 : (cnt_q == limit) ? '0 : cnt_q + 1'b1;
	assign sif.tick_rise = run && (cnt_q == limit);
	assign sif.tick_fall = run && (cnt_q == half);
	assign sif.conv_clk  = run && (cnt_q > half);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// Held in reset while disabled, so no converter edge can appear
	presc_held_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		!sif.enable |=> cnt_q == '0 || sif.enable)
		else $error("prescaler ran while disabled");
endmodule
`default_nettype wire

//--- design/acs_trig_sync.sv
/*
 * Trigger synchroniser and positive edge detector.
 * Assumes trigger pins are asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_trig_sync #(
	parameter int N_TRIG = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [N_TRIG-1:0] trig_i,
	acs_seq_if.trig                sif
);
	logic [N_TRIG-1:0] meta_q;
	logic [N_TRIG-1:0] sync_q;
	logic              prev_q;
	logic              edge_q;
	logic              sel_lvl;

	// Two flops, then one edge register: three CPU clocks of latency
	assign sel_lvl = sync_q[sif.trig_src];                      // R08

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			meta_q <= trig_i;
			sync_q <= meta_q;
			prev_q <= sel_lvl;
			edge_q <= sif.enable && sel_lvl && !prev_q;         // R24
		end
	end
	assign sif.trig_edge = edge_q;

	sequence s_pin_rise;
		$rose(sync_q[sif.trig_src]) && sif.enable && $stable(sif.trig_src);
	endsequence
	trig_latency_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
		s_pin_rise |=> sif.trig_edge)
		else $error("trigger edge not seen three clocks after pin");
endmodule
`default_nettype wire

//--- design/acs_sequencer.sv
/*
 * Conversion sequencer top: register port, start logic, conversion
 * timing, selection holding register and result double-read guard.
 * Assumes the analog front end presents its result on result_i by the
 * completion point, on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_sequencer #(
	parameter int N_TRIG = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [2:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	input  wire logic [N_TRIG-1:0] trig_i,
	input  wire logic [9:0]        result_i,
	output logic                   sample_hold_o,
	output logic                   busy_o,
	output logic                   conv_clk_o,
	output logic                   half_clk_o,
	output logic                   diff_o,
	output logic      [4:0]        channel_o,
	output logic      [1:0]        reference_o,
	output logic                   done_o
);
	acs_seq_if sif ();

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	acs_pkg::acs_state_t state_q;
	acs_pkg::acs_kind_t  kind_q;
	acs_pkg::acs_kind_t  kind_st;
	logic [`ACS_HC_W-1:0] hc_q;
	logic [`ACS_HC_W-1:0] hc_nx;
	logic [`ACS_HC_W-1:0] sh_hc;
	logic [`ACS_HC_W-1:0] done_hc;
	logic       en_q;
	logic       start_q;
	logic       auto_q;
	logic       done_q;
	logic [2:0] div_q;
	logic [2:0] src_q;
	logic [6:0] sel_hold_q;
	logic [6:0] sel_act_q;
	logic [9:0] res_q;
	logic       block_q;
	logic       first_q;
	logic       half_q;
	logic [7:0] rdata_q;
	logic       sh_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic wr_ctrl;
	logic wr_sel;
	logic wr_trig;
	logic rd_lo;
	logic rd_hi;
	logic tick;
	logic conv;
	logic free_run;
	logic auto_go;
	logic user_go;
	logic go;
	logic done_pulse;
	logic sh_pulse;
	logic sel_open;
	logic diff_sel;
	logic [7:0] ctrl_rd;
	logic [7:0] rd_mux;

	function automatic logic hit(input logic s, input logic [2:0] a,
	                             input logic [2:0] off);
		hit = s && (a == off);
	endfunction

	assign wr_ctrl = hit(wr_i, addr_i, `ACS_OFF_CTRL);
	assign wr_sel  = hit(wr_i, addr_i, `ACS_OFF_SEL);
	assign wr_trig = hit(wr_i, addr_i, `ACS_OFF_TRIG);
	assign rd_lo   = hit(rd_i, addr_i, `ACS_OFF_RES_LO);
	assign rd_hi   = hit(rd_i, addr_i, `ACS_OFF_RES_HI);

	assign sif.enable    = en_q;
	assign sif.divisor   = div_q;                              // R26
	assign sif.trig_src  = src_q;
	assign sif.presc_clr = auto_go;                            // R07

	acs_prescaler u_presc (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sif   (sif)
	);
	acs_trig_sync #(.N_TRIG(N_TRIG)) u_trig (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.trig_i (trig_i),
		.sif    (sif)
	);

	// ----------------------------------------------------------------
	// Start and timing
	// ----------------------------------------------------------------
	// Source zero means free running: restart at completion
	assign free_run = auto_q && (src_q == 3'h0);
	assign diff_sel = sel_act_q[`ACS_B_DIFF];
	assign tick     = sif.tick_rise || sif.tick_fall;
	assign conv     = state_q == acs_pkg::ACS_CONV;
	// Edges while converting are dropped, never queued
	assign auto_go  = en_q && auto_q && !free_run && !conv
	                  && sif.trig_edge;                        // R24
	assign user_go  = en_q && start_q && !conv && sif.tick_rise; // R02
	assign go       = auto_go || user_go;

	assign kind_st = auto_go ?
	                 ((first_q || diff_sel) ? acs_pkg::ACS_K_FIRST // R09
	                                        : acs_pkg::ACS_K_AUTO) :
	                 first_q ? acs_pkg::ACS_K_FIRST :           // R04
	                 (diff_sel && half_q) ? acs_pkg::ACS_K_DLONG // R12
	                                      : acs_pkg::ACS_K_NORMAL;

	always_comb begin
		case (kind_q)
		acs_pkg::ACS_K_FIRST: begin
			sh_hc   = `ACS_SH_FIRST;                            // R05
			done_hc = `ACS_DONE_FIRST;                          // R04
		end
		acs_pkg::ACS_K_AUTO: begin
			sh_hc   = `ACS_SH_AUTO;                             // R07
			done_hc = `ACS_DONE_AUTO;
		end
		acs_pkg::ACS_K_DLONG: begin
			sh_hc   = `ACS_SH_DLONG;                            // R11
			done_hc = `ACS_DONE_DLONG;                          // R12
		end
		default: begin
			sh_hc   = `ACS_SH_NORM;                             // R05
			done_hc = `ACS_DONE_NORM;                           // R03
		end
		endcase
	end

	assign hc_nx      = hc_q + 1'b1;
	assign sh_pulse   = conv && tick && (hc_nx == sh_hc);
	assign done_pulse = conv && tick && (hc_nx == done_hc);
	// Last full converter cycle reopens the selection path
	assign sel_open   = !conv || (hc_q >= done_hc - 6'h02);     // R16

	always_ff @(posedge clk_i) begin
		if (rst_i || !en_q) begin
			state_q <= acs_pkg::ACS_IDLE;
			kind_q  <= acs_pkg::ACS_K_NORMAL;
			hc_q    <= '0;
		end else if (go) begin
			state_q <= acs_pkg::ACS_CONV;
			kind_q  <= kind_st;
			hc_q    <= '0;
		end else if (done_pulse && free_run) begin           // R10
			kind_q  <= diff_sel ? acs_pkg::ACS_K_DLONG        // R13
			                    : acs_pkg::ACS_K_NORMAL;
			hc_q    <= '0;
		end else if (done_pulse) begin
			state_q <= acs_pkg::ACS_IDLE;
			hc_q    <= '0;
		end else if (conv && tick) begin
			hc_q    <= hc_nx;
		end
	end

	// Half-rate clock and first-conversion marker
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_q) begin
			half_q  <= 1'b0;                                    // R11
			first_q <= 1'b1;                                    // R04
		end else begin
			half_q  <= half_q ^ sif.tick_rise;
			first_q <= first_q && !go;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q   <= 1'b0;
			auto_q <= 1'b0;
			div_q  <= `ACS_DIV_RST;
			src_q  <= `ACS_SRC_RST;
		end else begin
			if (wr_ctrl) begin
				en_q   <= wdata_i[`ACS_B_EN];                    // R01
				auto_q <= wdata_i[`ACS_B_AUTO];
				div_q  <= wdata_i[2:0];
			end
			if (wr_trig)
				src_q <= wdata_i[2:0];
		end
	end

	// Start bit: written one, set by triggers, cleared at single done
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_q)
			start_q <= 1'b0;
		else if (go || (wr_ctrl && wdata_i[`ACS_B_START]))
			start_q <= 1'b1;
		else if (done_pulse && !free_run)
			start_q <= 1'b0;                                    // R06
	end

	// Done flag: hardware set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			done_q <= 1'b0;
		else if (done_pulse)
			done_q <= 1'b1;                                     // R06
		else if (wr_ctrl && wdata_i[`ACS_B_DONE])
			done_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Selection and result
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_hold_q <= `ACS_SEL_RST;
			sel_act_q  <= `ACS_SEL_RST;
		end else begin
			if (wr_sel)
				sel_hold_q <= wdata_i[6:0];                      // R15
			// Restart locks at completion, so a late change waits
			if (sel_open && !(done_pulse && free_run))
				sel_act_q <= sel_hold_q;                          // R20
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_q   <= '0;
			block_q <= 1'b0;
		end else begin
			if (done_pulse && !block_q)
				res_q <= result_i;                                // R23
			if (rd_lo)
				block_q <= 1'b1;
			else if (rd_hi)
				block_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	assign ctrl_rd = {en_q, start_q, auto_q, done_q, 1'b0, div_q};
	assign rd_mux  = (addr_i == `ACS_OFF_CTRL)   ? ctrl_rd :
	                 (addr_i == `ACS_OFF_SEL)    ? {1'b0, sel_hold_q} :
	                 (addr_i == `ACS_OFF_TRIG)   ? {5'h00, src_q} :
	                 (addr_i == `ACS_OFF_RES_LO) ? res_q[7:0] :
	                 (addr_i == `ACS_OFF_RES_HI) ? {6'h00, res_q[9:8]} :
	                 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
			sh_q    <= 1'b0;
		end else begin
			rdata_q <= rd_i ? rd_mux : 8'h00;
			sh_q    <= sh_pulse;
		end
	end

	assign rdata_o       = rdata_q;
	assign sample_hold_o = sh_q;
	assign busy_o        = conv;
	assign conv_clk_o    = sif.conv_clk;
	assign half_clk_o    = half_q;
	assign diff_o        = diff_sel;
	assign channel_o     = sel_act_q[4:0];
	assign reference_o   = {1'b0, sel_act_q[5]};
	assign done_o        = done_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [4:0] rises_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || go || (done_pulse && free_run) || !conv)
			rises_q <= '0;
		else if (sif.tick_rise)
			rises_q <= rises_q + 1'b1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !en_q);

	sequence s_done_single;
		done_pulse && !free_run;
	endsequence
	sequence s_user_start;
		!conv && start_q && sif.tick_rise && !auto_go;
	endsequence

	start_edge_a: assert property (s_user_start |=> conv && hc_q == 0) // R02
		else $error("user start missed the converter edge");
	norm_len_a: assert property (done_pulse &&                   // R03
		kind_q == acs_pkg::ACS_K_NORMAL |-> sif.tick_rise && rises_q == 12)
		else $error("normal conversion length wrong");
	first_len_a: assert property (done_pulse &&                  // R04
		kind_q == acs_pkg::ACS_K_FIRST |-> rises_q == 24)
		else $error("first conversion length wrong");
	sh_norm_a: assert property (sh_pulse &&                      // R05
		kind_q == acs_pkg::ACS_K_NORMAL |-> sif.tick_fall && rises_q == 1)
		else $error("normal sample point wrong");
	done_flag_a: assert property (s_done_single |=>              // R06
		done_q && !start_q && !conv)
		else $error("single completion did not finish cleanly");
	auto_sh_a: assert property (sh_pulse &&                      // R07
		kind_q == acs_pkg::ACS_K_AUTO |-> sif.tick_rise && rises_q == 1)
		else $error("auto sample point not two clocks after trigger");
	free_run_a: assert property (done_pulse && free_run |=>      // R10
		conv && start_q && hc_q == 0 ##1 conv)
		else $error("free running did not restart");
	dlong_len_a: assert property (done_pulse &&                  // R12
		kind_q == acs_pkg::ACS_K_DLONG |-> rises_q == 13)
		else $error("long differential length wrong");
	sel_lock_a: assert property (conv && !sel_open ##1 conv      // R15
		|-> $stable(sel_act_q))
		else $error("selection changed during conversion");
	block_a: assert property (block_q && !rd_hi && done_pulse    // R23
		|=> $stable(res_q) && done_q)
		else $error("blocked result was overwritten");
endmodule
`default_nettype wire

//--- tb/acs_front_model.sv
/*
 * Analog front end model: freezes the pin level at the sample strobe.
 * Assumes the bench supplies the pin level and shares the CPU clock.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
	input  wire logic       clk_i,
	input  wire logic       sample_i,
	input  wire logic [9:0] level_i,
	output var  logic [9:0] result_o
);
	initial result_o = 10'h155;
	// Held between strobes, as a real hold capacitor would be
	always @(posedge clk_i) begin
		if (sample_i) begin
			result_o <= level_i;
		end
	end
endmodule
`default_nettype wire

//--- tb/acs_sequencer_tb.sv
/*
 * Self-checking bench of the conversion sequencer.
 * Assumes the design files and the front end model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
	localparam int P = 8;
	logic       clk_i   = 1'b0;
	logic       rst_i   = 1'b1;
	logic [2:0] addr_i  = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic [7:0] trig_i  = 8'h00;
	logic [9:0] level   = 10'h000;
	logic [9:0] result_i;
	logic [7:0] rdata_o, v;
	logic       sh_o, busy_o, ck_o, hc_o, diff_o, done_o;
	logic [4:0] channel_o;
	logic [1:0] reference_o;
	logic       b_q = 1'b0, d_q = 1'b0, c_q = 1'b0, h_q = 1'b0;
	bit         blk = 1'b0;
	int         error_cnt = 0, comparisons = 0, cyc = 0, t0, l, s, i;
	int         seed = 32'h4f2b, res_exp = 0, n13 = 0, n14 = 0;
	int         q_br[$], q_bf[$], q_sh[$], q_dn[$], q_ck[$], q_ch[$];
	int         q_val[$], q_hc[$];

	acs_sequencer #(.N_TRIG(8)) acs_sequencer_i (.clk_i(clk_i),
		.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i),
		.result_i(result_i), .sample_hold_o(sh_o), .busy_o(busy_o),
		.conv_clk_o(ck_o), .half_clk_o(hc_o), .diff_o(diff_o),
		.channel_o(channel_o), .reference_o(reference_o), .done_o(done_o));
	acs_front_model acs_front_model_i (.clk_i(clk_i), .sample_i(sh_o),
		.level_i(level), .result_o(result_i));

	always #12.5 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// Event recorder and result model
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		b_q <= busy_o;
		d_q <= done_o;
		c_q <= ck_o;
		h_q <= hc_o;
		level <= 10'($random(seed));
		if (busy_o && !b_q) q_br.push_back(cyc);
		if (!busy_o && b_q) q_bf.push_back(cyc);
		if (ck_o && !c_q) q_ck.push_back(cyc);
		if (hc_o && !h_q) q_hc.push_back(cyc);
		if (sh_o) begin
			q_sh.push_back(cyc);
			q_ch.push_back(int'(channel_o));
			q_val.push_back(int'(level));
		end
		if (done_o && !d_q) begin
			q_dn.push_back(cyc);
			if (q_val.size() > 0) begin
				if (!blk) res_exp = q_val[0];
				q_val.pop_front();
			end
		end
		if (cyc > 20000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
	                   input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Edge ownership is the designer's choice, so counts get some slack
	function automatic bit inr(input int e, input int g);
		return g >= e - 3 && g <= e + 3;
	endfunction

	task automatic near(input string nm, input int e, input int g);
		chk(nm, 16'(e), inr(e, g) ? 16'(e) : 16'(g));
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		if (a == 3'h3) blk = 1'b1;
		if (a == 3'h4) blk = 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic until_n(ref int q[$], input int n);
		int k;
		for (k = 0; k < 2000 && q.size() < n; k++) @(posedge clk_i);
		if (q.size() < n) begin
			error_cnt++;
			close_out();
		end
	endtask

	task automatic clr();
		q_br.delete();
		q_bf.delete();
		q_sh.delete();
		q_dn.delete();
		q_ck.delete();
		q_ch.delete();
		q_val.delete();
		q_hc.delete();
	endtask

	// One conversion; optional reselection two converter cycles in
	task automatic conv(input logic [7:0] c, input logic [7:0] ns,
	                    input logic [4:0] os, output int ln, output int sh);
		clr();
		wr(3'h0, c);
		if (ns != 8'h00) begin
			repeat (2 * P) @(posedge clk_i);
			wr(3'h1, ns);
			repeat (P) @(posedge clk_i);
			chk("chan_lock", 16'(os), 16'(channel_o));
		end
		until_n(q_bf, 1);
		until_n(q_dn, 1);
		ln = q_bf[0] - q_br[0];
		sh = q_sh[0] - q_br[0];
	endtask

	task automatic res_chk();
		logic [7:0] lo, hi;
		rd(3'h3, lo);
		rd(3'h4, hi);
		chk("result", 16'(res_exp), {hi, lo});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 8; i++) begin
			wr(3'h0, 8'h80 | 8'(i));
			clr();
			until_n(q_ck, 3);
			chk("clk_period", 16'(2 << i), 16'(q_ck[2] - q_ck[1]));
		end
		wr(3'h0, 8'h00);
		clr();
		repeat (300) @(posedge clk_i);
		chk("clk_held", 16'h0, 16'(q_ck.size()));
		wr(3'h0, 8'h82);
		wr(3'h1, 8'h03);
		conv(8'hD2, 8'h00, 5'h00, l, s);
		near("first_len", 25 * P, l);
		near("first_sh", 27 * P / 2 + 1, s);
		res_chk();
		rd(3'h0, v);
		chk("ctrl_flags", 16'h10, 16'(v & 8'h50));
		conv(8'hD2, 8'h25, 5'h03, l, s);
		near("norm_len", 13 * P, l);
		near("norm_sh", 3 * P / 2 + 1, s);
		chk("chan_sh", 16'h03, 16'(q_ch[0]));
		chk("chan_new", 16'h05, 16'(channel_o));
		chk("ref_new", 16'h1, 16'(reference_o));
		rd(3'h3, v);
		conv(8'hD2, 8'h00, 5'h00, l, s);
		rd(3'h0, v);
		chk("done_kept", 16'h10, 16'(v & 8'h10));
		rd(3'h4, v);
		res_chk();
		wr(3'h6, 8'hFF);
		rd(3'h7, v);
		chk("unmapped", 16'h0, 16'(v));
		wr(3'h1, 8'h12);
		for (i = 0; i < 4; i++) begin
			repeat (i * P) @(posedge clk_i);
			conv(8'hD2, 8'h00, 5'h00, l, s);
			if (inr(13 * P, l) && inr(3 * P / 2 + 1, s)) n13++;
			if (inr(14 * P, l) && inr(5 * P / 2 + 1, s)) n14++;
			chk("diff_on", 16'h1, 16'(diff_o));
		end
		chk("diff_timing", 16'h4, 16'(n13 + n14));
		chk("diff_both", 16'h1, 16'(n13 > 0 && n14 > 0));
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h00);
		clr();
		wr(3'h0, 8'hF2);
		until_n(q_dn, 1);
		wr(3'h1, 8'h16);
		until_n(q_sh, 4);
		near("fr_period", 13 * P, q_sh[1] - q_sh[0]);
		near("fr_diff_period", 14 * P, q_sh[3] - q_sh[2]);
		chk("fr_chan_old", 16'h01, 16'(q_ch[1]));
		chk("fr_chan_new", 16'h16, 16'(q_ch[2]));
		until_n(q_hc, 3);
		chk("half_period", 16'(2 * P), 16'(q_hc[2] - q_hc[1]));
		rd(3'h0, v);
		chk("fr_start", 16'h1, 16'(v[6]));
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h82);
		conv(8'hD2, 8'h00, 5'h00, l, s);
		wr(3'h2, 8'h03);
		wr(3'h0, 8'hB2);
		clr();
		@(posedge clk_i);
		trig_i <= 8'h08;
		t0 = cyc;
		until_n(q_sh, 1);
		near("trig_sh", 3 + 2 * P + 1, q_sh[0] - t0);
		repeat (30) @(posedge clk_i);
		trig_i <= 8'h00;
		repeat (4) @(posedge clk_i);
		trig_i <= 8'h08;
		until_n(q_bf, 1);
		near("auto_len", 27 * P / 2, q_bf[0] - q_br[0]);
		repeat (150) @(posedge clk_i);
		chk("retrigger", 16'h1, 16'(q_br.size()));
		trig_i <= 8'h00;
		wr(3'h0, 8'h02);
		wr(3'h1, 8'h12);
		wr(3'h0, 8'hB2);
		clr();
		trig_i <= 8'h08;
		until_n(q_bf, 1);
		near("diff_auto_len", 25 * P, q_bf[0] - q_br[0]);
		close_out();
	end
endmodule
`default_nettype wire
